// ==== sfr_defines.vh ====
// constants shared by the flash status and boot configuration register logic
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH

// ===========================================================================
// command codes on the internal command port
`define SFR_OP_WREN       4'h1
`define SFR_OP_WRDI       4'h2
`define SFR_OP_RD_STATUS  4'h3
`define SFR_OP_WR_STATUS  4'h4
`define SFR_OP_RD_BOOT    4'h5
`define SFR_OP_WR_BOOT    4'h6
`define SFR_OP_WR_VOL     4'h7
`define SFR_OP_WR_ENH     4'h8
`define SFR_OP_PROGRAM    4'h9
`define SFR_OP_ERASE_SEC  4'ha
`define SFR_OP_ERASE_ALL  4'hb

// ===========================================================================
// device_status fields
`define SFR_ST_WP_DIS     7
`define SFR_ST_BP3        6
`define SFR_ST_TB         5
`define SFR_ST_BP_HI      4
`define SFR_ST_BP_LO      2
`define SFR_ST_WEL        1
`define SFR_ST_WIP        0

// ===========================================================================
// boot_configuration fields
`define SFR_NV_DUMMY_HI   15
`define SFR_NV_DUMMY_LO   12
`define SFR_NV_XIP_HI     11
`define SFR_NV_XIP_LO     9
`define SFR_NV_HOLD       4
`define SFR_NV_QUAD_N     3
`define SFR_NV_DUAL_N     2
`define SFR_NV_RESET_VAL  16'hffff
`define SFR_NV_KEEP_MASK  16'hffdc

// volatile and enhanced volatile configuration fields
`define SFR_VC_DUMMY_HI   7
`define SFR_VC_DUMMY_LO   4
`define SFR_VC_XIP_N      3
`define SFR_VC_WRAP_HI    1
`define SFR_VC_WRAP_LO    0
`define SFR_EV_QUAD_N     7
`define SFR_EV_DUAL_N     6

// ===========================================================================
// encodings
`define SFR_DUMMY_ZERO    4'h0
`define SFR_DUMMY_ALL1    4'hf
`define SFR_XIP_DISABLED  3'h7
`define SFR_XIP_RSVD_A    3'h5
`define SFR_XIP_RSVD_B    3'h6
`define SFR_WRAP_SEQ      2'h3
`define SFR_BP_NONE       4'h0

// cycle job kinds for the busy timer
`define SFR_JOB_STATUS    2'h0
`define SFR_JOB_BOOT      2'h1
`define SFR_JOB_PROGRAM   2'h2
`define SFR_JOB_ERASE     2'h3

`endif

// ==== sfr_busy_timer.v ====
// busy timer that holds write-in-progress for one internal write cycle
`include "sfr_defines.vh"
`default_nettype none

module sfr_busy_timer #(
	parameter CNT_W       = 16,
	parameter STATUS_CYC  = 16'h0040,
	parameter BOOT_CYC    = 16'h0040,
	parameter PROGRAM_CYC = 16'h0100,
	parameter ERASE_CYC   = 16'h0800
) (
	input  wire             core_clk,
	input  wire             rst_n,
	input  wire             start,
	input  wire [1:0]       job,
	output wire             busy,
	output wire             done
);

	reg  [CNT_W-1:0] cnt_ff;
	reg              busy_ff;
	reg  [CNT_W-1:0] load_val;

	// ===========================================================================
	// duration select
	always @* begin
		case (job)
			`SFR_JOB_STATUS:  load_val = STATUS_CYC;
			`SFR_JOB_BOOT:    load_val = BOOT_CYC;
			`SFR_JOB_PROGRAM: load_val = PROGRAM_CYC;
			default:          load_val = ERASE_CYC;
		endcase
	end

	// ===========================================================================
	// countdown; a start while busy is ignored, the caller never issues one
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff  <= {CNT_W{1'b0}};
			busy_ff <= 1'b0;
		end else if (start && !busy_ff) begin
			cnt_ff  <= load_val;
			busy_ff <= 1'b1;
		end else if (busy_ff) begin
			cnt_ff  <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
			if (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1})
				busy_ff <= 1'b0;
		end
	end

	assign busy = busy_ff;
	assign done = busy_ff && (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// ==== sfr_status_config.v ====
// status register, boot configuration and working configuration of the flash
// Operation
// - boot loads working config from boot register
// - volatile writes update working config immediately
// - lock bit plus low protect pin blocks status writes
// - top/bottom bit places protected region
// - nonzero protect field refuses program/erase inside
// - write latch clear at power-up; needed first
// - busy bit high during any write cycle
// - volatile status bits clear on reset
// - whole-array erase only with protect field zero
// - status read and write by dedicated commands
// - dummy code 0000 or 1111 gives default
// - boot execute-in-place mode from bits 11:9
// - bit 4 enables hold/reset pin function
// - bits 3/2 low select quad/dual protocol
// - boot register acts next power-on; delivered ffff
// - boot register via own commands; reserved ignored
// - both low boots quad: quad wins
`include "sfr_defines.vh"
`default_nettype none

module sfr_status_config #(
	parameter ADDR_W        = 23,
	parameter SECTOR_W      = 7,
	parameter DUMMY_DEFAULT = 4'hf,
	parameter STATUS_CYC    = 16'h0040,
	parameter BOOT_CYC      = 16'h0040,
	parameter PROGRAM_CYC   = 16'h0100,
	parameter ERASE_CYC     = 16'h0800
) (
	input  wire              core_clk,
	input  wire              rst_n,
	input  wire              wp_n_pin,
	input  wire [15:0]       nv_boot_stored,
	input  wire [7:0]        nv_status_stored,
	input  wire              cmd_valid,
	input  wire [3:0]        cmd_op,
	input  wire [15:0]       cmd_data,
	input  wire [ADDR_W-1:0] cmd_addr,
	output reg               cmd_done,
	output reg               cmd_refused,
	output reg  [15:0]       rd_data,
	output reg               rd_valid,
	output wire              busy,
	output wire              write_latch,
	output reg               nv_boot_commit,
	output reg  [15:0]       nv_boot_wdata,
	output reg               nv_status_commit,
	output reg  [7:0]        nv_status_wdata,
	output reg               mem_program_go,
	output reg               mem_erase_go,
	output reg               mem_erase_all_go,
	output reg  [ADDR_W-1:0] mem_addr,
	output wire [3:0]        work_dummy_cycles,
	output wire              work_xip_enable,
	output wire [2:0]        work_xip_mode,
	output wire              work_hold_enable,
	output wire              work_quad,
	output wire              work_dual,
	output wire [1:0]        work_wrap
);

	// ===========================================================================
	// write protect pin synchroniser
	reg        wp_meta_ff;
	reg        wp_sync_ff;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			wp_meta_ff <= 1'b1;
			wp_sync_ff <= 1'b1;
		end else begin
			wp_meta_ff <= wp_n_pin;
			wp_sync_ff <= wp_meta_ff;
		end
	end

	// ===========================================================================
	// register state
	reg        wp_dis_ff;
	reg        tb_ff;
	reg  [3:0] bp_ff;
	reg        wel_ff;
	reg [15:0] boot_ff;
	reg  [3:0] wk_dummy_ff;
	reg        wk_xip_n_ff;
	reg  [2:0] wk_xip_mode_ff;
	reg        wk_hold_ff;
	reg        wk_quad_n_ff;
	reg        wk_dual_n_ff;
	reg  [1:0] wk_wrap_ff;
	reg        tmr_start;
	reg  [1:0] tmr_job;
	reg  [1:0] tmr_job_ff;
	wire       tmr_busy;
	wire       tmr_done;

	sfr_busy_timer #(
		.CNT_W       (16),
		.STATUS_CYC  (STATUS_CYC),
		.BOOT_CYC    (BOOT_CYC),
		.PROGRAM_CYC (PROGRAM_CYC),
		.ERASE_CYC   (ERASE_CYC)
	) u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (tmr_start),
		.job      (tmr_job),
		.busy     (tmr_busy),
		.done     (tmr_done)
	);

	// ===========================================================================
	// protection decode
	wire              hw_locked = wp_dis_ff && !wp_sync_ff;
	wire              bp_any    = (bp_ff != `SFR_BP_NONE);
	wire [SECTOR_W-1:0] sector  = cmd_addr[ADDR_W-1 -: SECTOR_W];
	wire [SECTOR_W:0] bp_span;
	wire [SECTOR_W:0] bp_one    = {{SECTOR_W{1'b0}}, 1'b1};
	wire [SECTOR_W:0] bp_full   = {1'b1, {SECTOR_W{1'b0}}};
	wire              sector_prot;

	// protected span is 2^(bp-1) sectors; large codes clamp to the whole
	// array instead of shifting the one out and protecting nothing
	assign bp_span = (bp_ff == `SFR_BP_NONE) ? {(SECTOR_W+1){1'b0}} :
		(bp_ff > SECTOR_W) ? bp_full : (bp_one << (bp_ff - 4'h1));
	assign sector_prot = bp_any && (tb_ff ?
		({1'b0, sector} < bp_span) :
		({1'b0, sector} >= (bp_full - bp_span)));

	// ===========================================================================
	// command decode
	always @* begin
		cmd_refused = 1'b0;
		tmr_start   = 1'b0;
		tmr_job     = `SFR_JOB_STATUS;
		if (cmd_valid) begin
			case (cmd_op)
				`SFR_OP_WREN, `SFR_OP_WRDI, `SFR_OP_RD_STATUS: begin
					cmd_refused = 1'b0;
				end
				`SFR_OP_RD_BOOT, `SFR_OP_WR_VOL, `SFR_OP_WR_ENH: begin
					cmd_refused = tmr_busy;
				end
				`SFR_OP_WR_STATUS: begin
					cmd_refused = tmr_busy || !wel_ff || hw_locked;
					tmr_start   = !cmd_refused;
					tmr_job     = `SFR_JOB_STATUS;
				end
				`SFR_OP_WR_BOOT: begin
					cmd_refused = tmr_busy || !wel_ff;
					tmr_start   = !cmd_refused;
					tmr_job     = `SFR_JOB_BOOT;
				end
				`SFR_OP_PROGRAM: begin
					cmd_refused = tmr_busy || !wel_ff || sector_prot;
					tmr_start   = !cmd_refused;
					tmr_job     = `SFR_JOB_PROGRAM;
				end
				`SFR_OP_ERASE_SEC: begin
					cmd_refused = tmr_busy || !wel_ff || sector_prot;
					tmr_start   = !cmd_refused;
					tmr_job     = `SFR_JOB_ERASE;
				end
				`SFR_OP_ERASE_ALL: begin
					cmd_refused = tmr_busy || !wel_ff || bp_any;
					tmr_start   = !cmd_refused;
					tmr_job     = `SFR_JOB_ERASE;
				end
				default: begin
					cmd_refused = 1'b1;
				end
			endcase
		end
	end

	wire take = cmd_valid && !cmd_refused;

	// ===========================================================================
	// status register and write latch
	always @(posedge core_clk) begin
		if (!rst_n) begin
			// nonvolatile bits come back from the array, volatile ones clear
			wp_dis_ff <= nv_status_stored[`SFR_ST_WP_DIS];
			tb_ff     <= nv_status_stored[`SFR_ST_TB];
			bp_ff     <= {nv_status_stored[`SFR_ST_BP3],
				nv_status_stored[`SFR_ST_BP_HI:`SFR_ST_BP_LO]};
			wel_ff    <= 1'b0;
		end else begin
			if (take && cmd_op == `SFR_OP_WR_STATUS) begin
				wp_dis_ff <= cmd_data[`SFR_ST_WP_DIS];
				tb_ff     <= cmd_data[`SFR_ST_TB];
				bp_ff     <= {cmd_data[`SFR_ST_BP3],
					cmd_data[`SFR_ST_BP_HI:`SFR_ST_BP_LO]};
			end
			// a latch set that meets a cycle end is lost: busy does not refuse it, the clear wins
			if (tmr_done)
				wel_ff <= 1'b0;
			else if (take && cmd_op == `SFR_OP_WREN)
				wel_ff <= 1'b1;
			else if (take && cmd_op == `SFR_OP_WRDI)
				wel_ff <= 1'b0;
		end
	end

	assign busy        = tmr_busy;
	assign write_latch = wel_ff;

	// ===========================================================================
	// boot configuration and working configuration
	wire [15:0] boot_src = nv_boot_stored;
	wire [2:0]  boot_xip = boot_src[`SFR_NV_XIP_HI:`SFR_NV_XIP_LO];

	always @(posedge core_clk) begin
		if (!rst_n) begin
			boot_ff        <= boot_src;
			wk_dummy_ff    <= boot_src[`SFR_NV_DUMMY_HI:`SFR_NV_DUMMY_LO];
			// reserved codes treated like disabled
			wk_xip_n_ff    <= (boot_xip == `SFR_XIP_DISABLED) ||
				(boot_xip == `SFR_XIP_RSVD_A) || (boot_xip == `SFR_XIP_RSVD_B);
			wk_xip_mode_ff <= boot_xip;
			wk_hold_ff     <= boot_src[`SFR_NV_HOLD];
			wk_quad_n_ff   <= boot_src[`SFR_NV_QUAD_N];
			wk_dual_n_ff   <= boot_src[`SFR_NV_DUAL_N];
			wk_wrap_ff     <= `SFR_WRAP_SEQ;
		end else if (take) begin
			case (cmd_op)
				`SFR_OP_WR_BOOT: begin
					// stored now, working copy untouched until next boot
					boot_ff <= (cmd_data & `SFR_NV_KEEP_MASK) |
						(boot_ff & ~`SFR_NV_KEEP_MASK);
				end
				`SFR_OP_WR_VOL: begin
					wk_dummy_ff <= cmd_data[`SFR_VC_DUMMY_HI:`SFR_VC_DUMMY_LO];
					wk_xip_n_ff <= cmd_data[`SFR_VC_XIP_N];
					wk_wrap_ff  <= cmd_data[`SFR_VC_WRAP_HI:`SFR_VC_WRAP_LO];
				end
				`SFR_OP_WR_ENH: begin
					wk_quad_n_ff <= cmd_data[`SFR_EV_QUAD_N];
					wk_dual_n_ff <= cmd_data[`SFR_EV_DUAL_N];
				end
				default: begin
					wk_wrap_ff <= wk_wrap_ff;
				end
			endcase
		end
	end

	assign work_dummy_cycles = ((wk_dummy_ff == `SFR_DUMMY_ZERO) ||
		(wk_dummy_ff == `SFR_DUMMY_ALL1)) ? DUMMY_DEFAULT : wk_dummy_ff;
	assign work_xip_enable   = !wk_xip_n_ff;
	assign work_xip_mode     = wk_xip_mode_ff;
	assign work_hold_enable  = wk_hold_ff;
	assign work_quad         = !wk_quad_n_ff;
	assign work_dual         = !wk_dual_n_ff && wk_quad_n_ff;
	assign work_wrap         = wk_wrap_ff;

	// ===========================================================================
	// answers, array requests and nonvolatile commits
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_done         <= 1'b0;
			rd_valid         <= 1'b0;
			rd_data          <= 16'h0000;
			nv_boot_commit   <= 1'b0;
			nv_boot_wdata    <= `SFR_NV_RESET_VAL;
			nv_status_commit <= 1'b0;
			nv_status_wdata  <= 8'h00;
			mem_program_go   <= 1'b0;
			mem_erase_go     <= 1'b0;
			mem_erase_all_go <= 1'b0;
			mem_addr         <= {ADDR_W{1'b0}};
		end else begin
			cmd_done         <= take;
			rd_valid         <= take && (cmd_op == `SFR_OP_RD_STATUS ||
				cmd_op == `SFR_OP_RD_BOOT);
			mem_program_go   <= take && cmd_op == `SFR_OP_PROGRAM;
			mem_erase_go     <= take && cmd_op == `SFR_OP_ERASE_SEC;
			mem_erase_all_go <= take && cmd_op == `SFR_OP_ERASE_ALL;
			if (take)
				mem_addr <= cmd_addr;
			if (take && cmd_op == `SFR_OP_RD_STATUS)
				rd_data <= {8'h00, wp_dis_ff, bp_ff[3], tb_ff, bp_ff[2:0],
					wel_ff, tmr_busy};
			else if (take && cmd_op == `SFR_OP_RD_BOOT)
				rd_data <= boot_ff;
			// commits fire at the cycle end, with the values now held
			nv_boot_commit   <= tmr_done && tmr_job_ff == `SFR_JOB_BOOT;
			nv_status_commit <= tmr_done && tmr_job_ff == `SFR_JOB_STATUS;
			nv_boot_wdata    <= boot_ff;
			nv_status_wdata  <= {wp_dis_ff, bp_ff[3], tb_ff, bp_ff[2:0], 2'b00};
		end
	end

	// ===========================================================================
	// job kind in flight
	always @(posedge core_clk) begin
		if (!rst_n)
			tmr_job_ff <= `SFR_JOB_STATUS;
		else if (tmr_start)
			tmr_job_ff <= tmr_job;
	end

endmodule

`default_nettype wire

// ==== sfr_status_config_sva.sv ====
// assertion checker for the flash status and boot configuration logic
`include "sfr_defines.vh"
`default_nettype none
// ==========================================================
// checker
module sfr_status_config_sva (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic       cmd_refused,
	input wire logic       cmd_done,
	input wire logic       busy,
	input wire logic       write_latch,
	input wire logic       mem_erase_all_go,
	input wire logic [3:0] work_dummy_cycles,
	input wire logic       work_quad,
	input wire logic       work_dual
);
	logic vol_wr_ff;
	wire  take = cmd_valid && !cmd_refused;
	// only volatile writes may move the working config after boot
	always @(posedge core_clk) begin
		vol_wr_ff <= rst_n && take && (cmd_op == `SFR_OP_WR_VOL || cmd_op == `SFR_OP_WR_ENH);
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_wren_sets_latch: assert property (take && !busy && cmd_op == `SFR_OP_WREN |=> write_latch && cmd_done) else $error("latch not set");
	chk_write_needs_latch: assert property (cmd_valid && !write_latch && (cmd_op == `SFR_OP_WR_STATUS || cmd_op == `SFR_OP_PROGRAM || cmd_op == `SFR_OP_ERASE_ALL) |-> cmd_refused) else $error("write without latch taken");
	chk_busy_starts: assert property (take && cmd_op == `SFR_OP_WR_STATUS |=> busy && cmd_done) else $error("busy not raised");
	chk_busy_refuses: assert property (busy && cmd_valid && cmd_op == `SFR_OP_PROGRAM |-> cmd_refused) else $error("program taken while busy");
	chk_end_together: assert property ($fell(busy) |-> !write_latch) else $error("latch outlives busy");
	chk_reset_clears: assert property ($rose(rst_n) |-> !busy && !write_latch) else $error("volatile bits set after reset");
	chk_erase_all_go: assert property (take && cmd_op == `SFR_OP_ERASE_ALL |=> mem_erase_all_go && busy) else $error("erase all not started");
	chk_dummy_nonzero: assert property (work_dummy_cycles != 4'h0) else $error("dummy code zero not mapped");
	chk_quad_wins: assert property (work_quad |-> !work_dual) else $error("dual beside quad");
	chk_work_cause: assert property ($changed(work_dummy_cycles) || $changed(work_quad) |-> vol_wr_ff) else $error("working config moved");
	cov_status_wr: cover property (take && cmd_op == `SFR_OP_WR_STATUS);
	cov_status_ref: cover property (cmd_valid && cmd_refused && cmd_op == `SFR_OP_WR_STATUS);
	cov_erase_all: cover property (mem_erase_all_go);
endmodule
bind sfr_status_config sfr_status_config_sva i_sfr_status_config_sva (.core_clk, .rst_n,
	.cmd_valid, .cmd_op, .cmd_refused, .cmd_done, .busy, .write_latch, .mem_erase_all_go,
	.work_dummy_cycles, .work_quad, .work_dual);
`default_nettype wire

// ==== sfr_host_model.sv ====
// host side model that places commands on the command port
`default_nettype none
// ==========================================================
// host
module sfr_host_model (
	input wire logic         core_clk,
	input wire logic         req,
	input wire logic [3:0]   req_op,
	input wire logic [15:0]  req_data,
	input wire logic [22:0]  req_addr,
	output logic             cmd_valid,
	output logic [3:0]       cmd_op,
	output logic [15:0]      cmd_data,
	output logic [22:0]      cmd_addr
);
	logic [42:0] last_ff = '0;
	// idle lines show the inverse of the last command so stale values never pass
	always @(posedge core_clk) begin
		if (req) begin
			last_ff <= {req_op, req_data, req_addr};
		end
	end
	// status and boot registers only through their own commands
	assign cmd_valid = req;
	assign {cmd_op, cmd_data, cmd_addr} = req ? {req_op, req_data, req_addr} : ~last_ff;
endmodule
`default_nettype wire

// ==== sfr_status_config_tb.sv ====
// self-checking bench for the flash status and boot configuration logic
`include "sfr_defines.vh"
`default_nettype none
module sfr_status_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 4;
	logic        core_clk, rst_n, wp_n_pin, req, cmd_valid, cmd_done, cmd_refused, busy;
	logic        write_latch, work_xip_enable, work_hold_enable, work_quad, work_dual;
	logic [3:0]  r_op, cmd_op, work_dummy_cycles;
	logic [2:0]  work_xip_mode;
	logic [15:0] r_data, cmd_data, rd_data, nv_boot;
	logic [22:0] r_addr, cmd_addr;
	logic        refd, done, rdv, rd_valid;
	logic [1:0]  wrap;
	int          fails, n_compared, cycles, n;
	sfr_host_model i_sfr_host_model (.core_clk(core_clk), .req(req), .req_op(r_op),
		.req_data(r_data), .req_addr(r_addr), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .cmd_addr(cmd_addr));
	sfr_status_config #(.STATUS_CYC(CYC), .BOOT_CYC(CYC), .PROGRAM_CYC(CYC), .ERASE_CYC(CYC))
	i_sfr_status_config (.core_clk(core_clk), .rst_n(rst_n), .wp_n_pin(wp_n_pin),
		.nv_boot_stored(nv_boot), .nv_status_stored(8'h00), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_addr(cmd_addr), .cmd_done(cmd_done),
		.cmd_refused(cmd_refused), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
		.write_latch(write_latch), .nv_boot_commit(), .nv_boot_wdata(), .nv_status_commit(),
		.nv_status_wdata(), .mem_program_go(), .mem_erase_go(), .mem_erase_all_go(),
		.mem_addr(), .work_dummy_cycles(work_dummy_cycles), .work_xip_enable(work_xip_enable),
		.work_xip_mode(work_xip_mode), .work_hold_enable(work_hold_enable),
		.work_quad(work_quad), .work_dual(work_dual), .work_wrap(wrap));
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [15:0] d, input logic [22:0] a);
		@(posedge core_clk);
		req <= 1'b1;
		r_op <= op;
		r_data <= d;
		r_addr <= a;
		@(negedge core_clk);
		refd = cmd_refused;
		@(posedge core_clk);
		req <= 1'b0;
		@(negedge core_clk);
		done = cmd_done;
		rdv = rd_valid;
	endtask
	task automatic wait_idle();
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic do_reset(input logic [15:0] boot);
		@(posedge core_clk);
		rst_n <= 1'b0;
		nv_boot <= boot;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
	endtask
	// write latch, then a program or erase; refusal compared with the expectation
	task automatic prog(input logic [3:0] op, input logic [6:0] sec, input logic exp);
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		cmd(op, 16'h0, {sec, 16'h0});
		chk(16'(refd), 16'(exp));
		wait_idle();
	endtask
	// ==========================================================
	// scenarios
	task automatic t_boot();
		logic [15:0] boots [4] = '{16'h0800, 16'h3bfb, 16'h1200, 16'hffff};
		logic [10:0] exps [4] = '{11'h7e2, 11'h185, 11'h0ca, 11'h784};
		for (int i = 0; i < 4; i++) begin
			do_reset(boots[i]);
			chk(16'({work_dummy_cycles, work_xip_enable, work_xip_enable ? work_xip_mode : 3'h0,
				work_hold_enable, work_quad, work_dual}), 16'(exps[i]));
			chk(16'({wrap, write_latch, busy}), 16'h000c);
		end
		$display("t_boot done");
	endtask
	task automatic t_bootwr();
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		cmd(`SFR_OP_WR_BOOT, 16'h0000, 23'h0);
		chk(16'(done), 16'h1);
		wait_idle();
		chk(16'(n), 16'(CYC));
		chk(16'({work_dummy_cycles, write_latch}), 16'h1e);
		cmd(`SFR_OP_RD_BOOT, 16'h0, 23'h0);
		chk(rd_data, 16'h0023);
		$display("t_bootwr done");
	endtask
	task automatic t_vol();
		cmd(`SFR_OP_WR_VOL, 16'h0057, 23'h0);
		chk(16'({work_dummy_cycles, work_xip_enable}), 16'h0b);
		chk(16'(wrap), 16'h0003);
		cmd(`SFR_OP_WR_ENH, 16'h0040, 23'h0);
		chk(16'(work_quad), 16'h1);
		cmd(`SFR_OP_WR_VOL, 16'h0008, 23'h0);
		chk(16'(work_dummy_cycles), 16'h000f);
		chk(16'(wrap), 16'h0000);
		$display("t_vol done");
	endtask
	task automatic t_status();
		cmd(`SFR_OP_WR_STATUS, 16'h0020, 23'h0);
		chk(16'(refd), 16'h1);
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		chk(16'(write_latch), 16'h1);
		cmd(`SFR_OP_WR_STATUS, 16'h0024, 23'h0);
		wait_idle();
		chk(16'({n[3:0], write_latch}), 16'({CYC[3:0], 1'b0}));
		cmd(`SFR_OP_RD_STATUS, 16'h0, 23'h0);
		chk(rd_data, 16'h0024);
		chk(16'(rdv), 16'h0001);
		prog(`SFR_OP_PROGRAM, 7'd0, 1'b1);
		prog(`SFR_OP_ERASE_SEC, 7'd127, 1'b0);
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		cmd(`SFR_OP_WR_STATUS, 16'h0098, 23'h0);
		wait_idle();
		prog(`SFR_OP_PROGRAM, 7'd96, 1'b1);
		prog(`SFR_OP_ERASE_SEC, 7'd95, 1'b0);
		prog(`SFR_OP_ERASE_ALL, 7'd0, 1'b1);
		wp_n_pin <= 1'b0;
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		cmd(`SFR_OP_WR_STATUS, 16'h0000, 23'h0);
		chk(16'(refd), 16'h1);
		wp_n_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		cmd(`SFR_OP_WR_STATUS, 16'h0000, 23'h0);
		chk(16'(refd), 16'h0);
		wait_idle();
		prog(`SFR_OP_ERASE_ALL, 7'd0, 1'b0);
		cmd(`SFR_OP_WREN, 16'h0, 23'h0);
		cmd(`SFR_OP_WRDI, 16'h0, 23'h0);
		cmd(`SFR_OP_RD_STATUS, 16'h0, 23'h0);
		chk(rd_data, 16'h0000);
		$display("t_status done");
	endtask
	// ==========================================================
	// clock, timeout, sequence
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		{rst_n, req, r_op, r_data, r_addr, fails, n_compared, cycles} = '0;
		wp_n_pin = 1'b1;
		nv_boot = 16'hffff;
		t_boot();
		t_bootwr();
		t_vol();
		t_status();
		t_boot();
		report_and_stop();
	end
endmodule
`default_nettype wire
